// file: hdl/period_timer_defs.svh
`ifndef PERIOD_TIMER_DEFS_SVH
`define PERIOD_TIMER_DEFS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ------------------------------------------------------------
`define ADDR_CTRL      4'h0
`define ADDR_IOCTRL    4'h1
`define ADDR_MODE      4'h2
`define ADDR_PRESCALE  4'h3
`define ADDR_MAIN      4'h4

// ------------------------------------------------------------
// Control register bit positions
// ------------------------------------------------------------
`define CTRL_START_BIT  0
`define CTRL_STATUS_BIT 1
`define CTRL_HALT_BIT   2
`define CTRL_EDGE_BIT   4
`define CTRL_UNDF_BIT   5

// ------------------------------------------------------------
// I/O control register bit positions
// ------------------------------------------------------------
`define IO_EDGE_SEL_BIT 0
`define IO_PIN_SEL_BIT  2
`define IO_FILT_LO_BIT  4
`define IO_FILT_HI_BIT  5

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define MODE_CLK_LO_BIT 4
`define MODE_CLK_HI_BIT 5

// ------------------------------------------------------------
// Reset values and timing counts
// ------------------------------------------------------------
`define RST_BYTE        8'hff
`define RST_ZERO        8'h00
`define DIV_F2          4'h1
`define DIV_F8          4'h7
`define FILT_TAPS       3
`define FILT_DIV_A      4'h0
`define FILT_DIV_B      4'h7
`define FILT_DIV_C      5'h1f

`endif

// file: hdl/period_timer_pkg.sv
package period_timer_pkg;

  // Count source selection
  typedef enum logic [1:0] {
    SRC_F1,
    SRC_F8,
    SRC_OSC,
    SRC_F2
  } count_src_t;

  // Start/stop synchroniser states
  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_ARM,
    RUN_COUNT,
    RUN_DRAIN
  } run_state_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Block state apart from the input synchronisers
  typedef struct packed {
    run_state_t run;
    logic       start;
    logic       edge_flag;
    logic       undf_flag;
    logic       edge_sel;
    logic       pin_sel;
    logic [1:0] filt_sel;
    logic [1:0] clk_sel;
    logic [7:0] pre_reload;
    logic [7:0] pre_cnt;
    logic [7:0] main_reload;
    logic [7:0] main_cnt;
    logic [7:0] readout;
    logic       pre_load_pend;
    logic       main_load_pend;
    logic [1:0] cap_phase;
    logic [4:0] div_cnt;
    logic [4:0] filt_div;
    logic [2:0] filt_shift;
    logic       filt_out;
    logic       filt_prev;
    logic       edge_seen;
    logic       irq;
    logic [7:0] rdata;
  } timer_state_t;

endpackage : period_timer_pkg

// file: hdl/pulse_period_measure_timer.sv
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "period_timer_defs.svh"

module pulse_period_measure_timer
  import period_timer_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       osc_clk_in,
  input  wire logic       port_pin_alt_a_in,
  input  wire logic       port_pin_alt_b_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            timer_irq_out,
  output logic            count_status_flag_out
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [1:0]   sync_a;
  logic [1:0]   sync_b;
  logic [1:0]   sync_osc;
  logic         osc_prev;
  reg_req_t     req;
  timer_state_t s;
  timer_state_t next_s;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Two flops per asynchronous input, first flop read only by second
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync_a   <= 2'h0;
      sync_b   <= 2'h0;
      sync_osc <= 2'h0;
      osc_prev <= 1'b0;
    end
    else
    begin
      sync_a   <= {sync_a[0], port_pin_alt_a_in};
      sync_b   <= {sync_b[0], port_pin_alt_b_in};
      sync_osc <= {sync_osc[0], osc_clk_in};
      osc_prev <= sync_osc[1];
    end
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  logic       tick;
  logic       pre_uf;
  logic       main_uf;
  logic       pin_lvl;
  logic       filt_tick;
  logic       active_edge;
  logic       counting;
  logic [7:0] ctrl_rd;

  always_comb
  begin
    next_s      = s;
    tick        = 1'b0;
    pre_uf      = 1'b0;
    main_uf     = 1'b0;
    filt_tick   = 1'b0;
    active_edge = 1'b0;
    counting    = (s.run == RUN_COUNT);
    next_s.irq  = 1'b0;

    // Count source divider
    next_s.div_cnt = s.div_cnt + 5'h1;
    unique case (count_src_t'(s.clk_sel))
      SRC_F1:  tick = 1'b1;
      SRC_F2:  tick = (s.div_cnt[3:0] & `DIV_F2) == `DIV_F2;
      SRC_F8:  tick = (s.div_cnt[3:0] & `DIV_F8) == `DIV_F8;
      SRC_OSC: tick = sync_osc[1] & ~osc_prev;
    endcase

    pin_lvl = s.pin_sel ? sync_b[1] : sync_a[1];

    next_s.filt_div = s.filt_div + 5'h1;
    unique case (s.filt_sel)
      2'h0: filt_tick = 1'b0;
      2'h1: filt_tick = 1'b1;
      2'h2: filt_tick = (s.filt_div[3:0] & `FILT_DIV_B) == `FILT_DIV_B;
      2'h3: filt_tick = s.filt_div == `FILT_DIV_C;
    endcase
    if (s.filt_sel == 2'h0)
      next_s.filt_out = pin_lvl;
    else if (filt_tick)
    begin
      next_s.filt_shift = {s.filt_shift[1:0], pin_lvl};
      if (&s.filt_shift)
        next_s.filt_out = 1'b1;
      else if (~|s.filt_shift)
        next_s.filt_out = 1'b0;
    end
    next_s.filt_prev = s.filt_out;

    // rising (0) or falling (1) interval
    if (s.edge_sel ? (s.filt_prev & ~s.filt_out)
                   : (~s.filt_prev & s.filt_out))
      active_edge = counting;
    if (active_edge)
      next_s.edge_seen = 1'b1;

    // status rises on next count-source tick
    // status falls on next count-source tick
    unique case (s.run)
      RUN_IDLE:  if (s.start) next_s.run = RUN_ARM;
      RUN_ARM:   if (!s.start) next_s.run = RUN_IDLE;
                 else if (tick) next_s.run = RUN_COUNT;
      RUN_COUNT: if (!s.start) next_s.run = RUN_DRAIN;
      RUN_DRAIN: if (tick) next_s.run = RUN_IDLE;
    endcase

    if (counting && tick)
    begin
      if (s.pre_load_pend || s.pre_cnt == 8'h00)
      begin
        next_s.pre_cnt       = s.pre_reload;
        next_s.pre_load_pend = 1'b0;
        pre_uf               = (s.pre_cnt == 8'h00);
      end
      else
        next_s.pre_cnt = s.pre_cnt - 8'h01;
    end

    if (pre_uf)
    begin
      // capture at first underflow after edge
      // a pending edge shows on first underflow
      if (s.edge_seen && s.cap_phase == 2'h0)
      begin
        next_s.readout   = s.main_cnt;
        next_s.cap_phase = 2'h1;
        next_s.edge_seen = 1'b0;
      end
      if (s.cap_phase == 2'h1 || s.main_load_pend || s.main_cnt == 8'h00)
      begin
        main_uf               = (s.main_cnt == 8'h00) || s.cap_phase == 2'h1;
        next_s.main_cnt       = s.main_reload;
        next_s.main_load_pend = 1'b0;
        next_s.cap_phase      = 2'h0;
      end
      else
        next_s.main_cnt = s.main_cnt - 8'h01;
    end

    // sticky flags, set wins over clear
    if (req.wr && req.addr == `ADDR_CTRL)
    begin
      if (!req.wdata[`CTRL_EDGE_BIT])
        next_s.edge_flag = 1'b0;
      if (!req.wdata[`CTRL_UNDF_BIT])
        next_s.undf_flag = 1'b0;
      next_s.start = req.wdata[`CTRL_START_BIT];
    end
    if (active_edge)
      next_s.edge_flag = 1'b1;
    if (main_uf)
      next_s.undf_flag = 1'b1;

    next_s.irq = main_uf | active_edge;

    if (req.wr && req.addr == `ADDR_CTRL && req.wdata[`CTRL_HALT_BIT])
    begin
      next_s.start = 1'b0;
      next_s.run   = RUN_IDLE;
    end

    if (req.wr)
    begin
      unique case (req.addr)
        `ADDR_IOCTRL:
        begin
          next_s.edge_sel = req.wdata[`IO_EDGE_SEL_BIT];
          next_s.pin_sel  = req.wdata[`IO_PIN_SEL_BIT];
          next_s.filt_sel = req.wdata[`IO_FILT_HI_BIT:`IO_FILT_LO_BIT];
        end
        `ADDR_MODE:
          next_s.clk_sel = req.wdata[`MODE_CLK_HI_BIT:`MODE_CLK_LO_BIT];
        `ADDR_PRESCALE:
        begin
          next_s.pre_reload = req.wdata;
          if (counting)
            next_s.pre_load_pend = 1'b1;
          else
            next_s.pre_cnt = req.wdata;
        end
        `ADDR_MAIN:
        begin
          next_s.main_reload = req.wdata;
          if (counting)
            next_s.main_load_pend = 1'b1;
          else
            next_s.main_cnt = req.wdata;
        end
        default: ;
      endcase
    end

    // each byte is its own access
    ctrl_rd = 8'h00;
    ctrl_rd[`CTRL_START_BIT]  = s.start;
    ctrl_rd[`CTRL_STATUS_BIT] = (s.run == RUN_COUNT) || (s.run == RUN_DRAIN);
    ctrl_rd[`CTRL_EDGE_BIT]   = s.edge_flag;
    ctrl_rd[`CTRL_UNDF_BIT]   = s.undf_flag;
    next_s.rdata = 8'h00;
    if (req.rd)
    begin
      unique case (req.addr)
        `ADDR_CTRL:     next_s.rdata = ctrl_rd;
        `ADDR_IOCTRL:   next_s.rdata = {2'h0, s.filt_sel, 1'b0,
                                         s.pin_sel, 1'b0, s.edge_sel};
        `ADDR_MODE:     next_s.rdata = {2'h0, s.clk_sel, 4'h0};
        `ADDR_PRESCALE: next_s.rdata = s.pre_cnt;
        `ADDR_MAIN:     next_s.rdata = s.main_cnt;
        default:        next_s.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // stopped after reset
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      s             <= '0;
      s.run         <= RUN_IDLE;
      s.pre_reload  <= `RST_BYTE;
      s.pre_cnt     <= `RST_BYTE;
      s.main_reload <= `RST_BYTE;
      s.main_cnt    <= `RST_BYTE;
      s.readout     <= `RST_ZERO;
    end
    else
      s <= next_s;
  end

  // Read data and irq from flops, count status decoded from the run state
  assign rdata_out             = s.rdata;
  assign timer_irq_out         = s.irq;
  assign count_status_flag_out = (s.run == RUN_COUNT) || (s.run == RUN_DRAIN);

endmodule : pulse_period_measure_timer

// file: verif/pulse_src_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Measured pulse source on the two alternative pins
// ------------------------------------------------------------
module pulse_src_model #(
  parameter int MIN_W = 10
) (
  input  wire logic ref_clk_in,
  output logic      pin_a_out,
  output logic      pin_b_out
);
  // Both pins rest low
  initial
  begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end

  task automatic drive(input logic sel, input logic v, input int n);
    if (sel)
      pin_b_out <= v;
    else
      pin_a_out <= v;
    repeat ((n < MIN_W) ? MIN_W : n) @(posedge ref_clk_in);
  endtask : drive
endmodule : pulse_src_model

// file: verif/pulse_period_measure_timer_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module timer_port_checker (
  input wire logic       ref_clk_in,
  input wire logic       rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       timer_irq_out,
  input wire logic       count_status_flag_out
);
  logic armed;
  logic ctl_wr;
  assign ctl_wr = wr_in && addr_in == 4'h0;

  // Start bit as last written, held low when the halt bit is written with it
  always_ff @(posedge ref_clk_in or negedge rstn_in)
    if (!rstn_in)
      armed <= 1'b0;
    else if (ctl_wr)
      armed <= wdata_in[0] && !wdata_in[2];

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (rd_in && addr_in > 4'h4 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  start_rise_a: assert property (ctl_wr && wdata_in[0] && !wdata_in[2] |-> ##[1:20] count_status_flag_out)
    else $error("status did not rise");
  halt_stop_a: assert property (ctl_wr && wdata_in[2] |-> ##[1:2] !count_status_flag_out)
    else $error("halt did not stop");
  stop_fall_a: assert property (ctl_wr && !wdata_in[0] |-> ##[1:20] !count_status_flag_out)
    else $error("status did not fall");
  rise_armed_a: assert property ($rose(count_status_flag_out) |-> armed)
    else $error("count began unasked");
  fell_disarmed_a: assert property ($fell(count_status_flag_out) |-> !armed)
    else $error("count ended unasked");
  irq_counting_a: assert property (timer_irq_out |-> $past(count_status_flag_out))
    else $error("irq while stopped");
  reset_idle_a: assert property (disable iff (1'b0) !rstn_in |-> !count_status_flag_out && !timer_irq_out && rdata_out == 8'h00)
    else $error("outputs active in reset");

  irq_seen_c: cover property (timer_irq_out);
  run_seen_c: cover property ($rose(count_status_flag_out));
  main_read_c: cover property (rd_in && addr_in == 4'h4);
endmodule : timer_port_checker

// file: verif/pulse_period_measure_timer_bench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module pulse_period_measure_timer_bench;
  logic       clk = 0, rstn, osc = 0, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, rdata, a, b;
  logic       irq, status, pin_a, pin_b;
  int         miscompares, n_checks, cyc, irq_cnt;

  pulse_period_measure_timer i_dut (.ref_clk_in(clk), .rstn_in(rstn),
    .osc_clk_in(osc), .port_pin_alt_a_in(pin_a), .port_pin_alt_b_in(pin_b),
    .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .timer_irq_out(irq), .count_status_flag_out(status));
  pulse_src_model i_src (.ref_clk_in(clk), .pin_a_out(pin_a), .pin_b_out(pin_b));

  // Clocks, irq monitor, timeout
  initial forever #5 clk = ~clk;
  initial forever #20 osc = ~osc;
  always @(negedge clk) if (irq === 1'b1) irq_cnt++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
    wr <= 1'b1; addr <= ad; wd <= d;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] ad, output logic [7:0] d);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    // Read data stand in the cycle after the strobe
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  task automatic exp_rd(input logic [3:0] ad, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(ad, d);
    check(d, e);
  endtask : exp_rd

  task automatic flag_is(input logic e);
    logic [7:0] d;
    rd_reg(4'h0, d);
    check({7'h00, d[4]}, {7'h00, e});
  endtask : flag_is

  task automatic wait_status(input logic v);
    for (int i = 0; i < 40 && status !== v; i++) @(negedge clk);
    check({7'h00, status}, {7'h00, v});
    @(posedge clk);
  endtask : wait_status

  task automatic t_count();
    exp_rd(4'h3, 8'hff); exp_rd(4'h4, 8'hff);
    exp_rd(4'h0, 8'h00); exp_rd(4'h9, 8'h00);
    wr_reg(4'h3, 8'h03); wr_reg(4'h4, 8'h40);
    exp_rd(4'h3, 8'h03); exp_rd(4'h4, 8'h40);
    // flags cleared before the count starts
    wr_reg(4'h0, 8'h00);
    flag_is(1'b0);
    wr_reg(4'h0, 8'h01);
    wait_status(1'b1);
    repeat (30) @(posedge clk);
    wr_reg(4'h0, 8'h01);
    rd_reg(4'h0, a);
    check(a & 8'h33, 8'h03);
    rd_reg(4'h4, a); repeat (6) @(posedge clk); rd_reg(4'h4, b);
    check(b, a - 8'h02);
    // Main write while counting lands at a prescaler underflow
    wr_reg(4'h4, 8'h10);
    repeat (8) @(posedge clk);
    rd_reg(4'h4, a);
    check({7'h00, (a == 8'h0f) || (a == 8'h0e)}, 8'h01);
    // Prescaler write while counting lands at the next tick
    wr_reg(4'h3, 8'h01);
    rd_reg(4'h3, a);
    check(a, 8'h01);
    wr_reg(4'h3, 8'h03);
    $display("count test done");
  endtask : t_count

  task automatic t_edge();
    irq_cnt = 0;
    wr_reg(4'h1, 8'h00);
    i_src.drive(1'b0, 1'b1, 20);
    flag_is(1'b1);
    rd_reg(4'h0, a);
    check({7'h00, a[5]}, 8'h01);
    check({7'h00, irq_cnt > 0}, 8'h01);
    wr_reg(4'h0, 8'h31); flag_is(1'b1);
    wr_reg(4'h0, 8'h21); flag_is(1'b0);
    i_src.drive(1'b0, 1'b0, 20); flag_is(1'b0);
    wr_reg(4'h1, 8'h01);
    i_src.drive(1'b0, 1'b1, 20); flag_is(1'b0);
    i_src.drive(1'b0, 1'b0, 20); flag_is(1'b1);
    wr_reg(4'h0, 8'h01); wr_reg(4'h1, 8'h04);
    i_src.drive(1'b0, 1'b1, 20); flag_is(1'b0);
    i_src.drive(1'b1, 1'b1, 20); flag_is(1'b1);
    i_src.drive(1'b0, 1'b0, 20); i_src.drive(1'b1, 1'b0, 20);
    $display("edge test done");
  endtask : t_edge

  task automatic t_filter();
    for (int f = 0; f < 4; f++)
    begin
      wr_reg(4'h1, 8'(f << 4)); wr_reg(4'h0, 8'h01);
      i_src.drive(1'b0, 1'b1, 200); flag_is(1'b1);
      i_src.drive(1'b0, 1'b0, 200);
    end
    wr_reg(4'h0, 8'h05); wait_status(1'b0);
    rd_reg(4'h4, a); repeat (8) @(posedge clk); exp_rd(4'h4, a);
    $display("filter and halt test done");
  endtask : t_filter

  task automatic t_src();
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(4'h0, 8'h00); wait_status(1'b0);
      wr_reg(4'h2, 8'(s << 4)); wr_reg(4'h4, 8'h40);
      wr_reg(4'h0, 8'h01); wait_status(1'b1);
      repeat (100) @(posedge clk);
      rd_reg(4'h4, a);
      check({7'h00, a < 8'h40}, 8'h01);
    end
    $display("source test done");
  endtask : t_src

  task automatic test_done();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Reset, then the scenarios in turn
  initial
  begin
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_count(); t_edge(); t_filter(); t_src();
    test_done();
  end
endmodule : pulse_period_measure_timer_bench

bind pulse_period_measure_timer timer_port_checker i_chk (.ref_clk_in,
  .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .timer_irq_out,
  .count_status_flag_out);
